// *** rtl/cpu_io_if.sv ***
// processor i/o bus between the board and the processor end
`timescale 1ns/1ps
`default_nettype none
interface cpu_io_if;
   logic [15:0] addr;
   logic [7:0]  dout;                  // processor to board
   logic [7:0]  din;                   // board to processor
   logic        din_oe_n;              // board drives din while low
   logic        io_read_cycle_status;
   logic        io_write_cycle_status;
   logic        cpu_bus_in_strobe;
   logic        cpu_write_strobe_n;
   logic        cpu_ready_line;
   logic        cpu_wait_ack;
   modport board (input addr, dout, io_read_cycle_status, io_write_cycle_status,
                  cpu_bus_in_strobe, cpu_write_strobe_n, cpu_wait_ack,
                  output din, din_oe_n, cpu_ready_line);
   modport cpu (output addr, dout, io_read_cycle_status, io_write_cycle_status,
                cpu_bus_in_strobe, cpu_write_strobe_n, cpu_wait_ack,
                input din, din_oe_n, cpu_ready_line);
endinterface
`default_nettype wire

// *** rtl/sio_board.sv ***
// dual serial port board: bus decode, control/status, fifo and serial engines
// Functional notes
// - processor uses two-byte IN/OUT, three machine cycles
// - port address duplicated on both address halves
// - processor drives read or write cycle status
// - board drives selected register during bus-in strobe
// - board captures data during write strobe
// - address bits 7..2 match six-bit jumper setting
// - bit 0 picks register, bit 1 port
// - control write, status read, data write/read
// - processor avoids address 255
// - each port owns a write-only control register
// - bits 1:0 select divide 1/16/64 or reset
// - software resets port then selects divide 16
// - divide 64 gives quarter of selected rate
// - bit4 clear: seven bits, stop/parity table
// - bit4 set: eight bits, stop/parity table
// - bits 6:5 set RTS, tx interrupt, break
// - bit 7 enables receive interrupt
// - typical init writes 003 then 261
// - status bit0 receive full, bit1 transmit empty
// - status bit7 mirrors interrupt request
// - input cycle drops ready until wait acknowledge
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// fifo
// ---------------------------------------------------------------
module sio_fifo
   import sio_pkg::*;
#(parameter int W = 8, parameter int D = FIFO_D) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic         clr,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp_ff, rp_ff;
   wire          full  = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
   wire          empty = (wp_ff == rp_ff);
   wire          push  = in_valid & ~full;
   wire          pop   = out_ready & ~empty;
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = mem[rp_ff[AW-1:0]];
   // pointers carry one extra bit so full and empty are distinct
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wp_ff <= '0;
         rp_ff <= '0;
      end else begin
         wp_ff <= clr ? '0 : wp_ff + (AW+1)'(push);
         rp_ff <= clr ? '0 : rp_ff + (AW+1)'(pop);
      end
   end
   // storage has no reset, only written on push
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_ff[AW-1:0]] <= in_data;
      end
   end
endmodule
// ---------------------------------------------------------------
// board top
// ---------------------------------------------------------------
module sio_board
   import sio_pkg::*;
#(parameter int TICK_DIV = TICK_DEF) (
   input  wire logic       mclk,
   input  wire logic       resetn,
   cpu_io_if.board         bus,
   input  wire logic [5:0] base_sel,
   input  wire logic [1:0] rxd,
   output logic [1:0]      txd,
   output logic [1:0]      rts_n,
   output logic [1:0]      irq_n
);
   logic [15:0] tick_cnt_ff;
   logic        wr_n_q_ff, bin_q_ff, rdsel_q_ff, rdy_ff, oe_n_ff;
   logic [7:0]  wcnt_ff, din_ff;
   logic [7:0]  stat [2], rxdat [2];
   // decode: only a jumper match lets the board answer at all
   wire sel    = (bus.addr[A_BHI:A_BLO] == base_sel);
   wire rd_sel = sel & bus.io_read_cycle_status;
   wire wr_sel = sel & bus.io_write_cycle_status;
   wire wr_pulse = wr_sel & ~bus.cpu_write_strobe_n & wr_n_q_ff;
   wire rd_pulse = rd_sel & bus.cpu_bus_in_strobe & ~bin_q_ff;
   wire pidx = bus.addr[A_PORT];
   wire isdat = bus.addr[A_REG];
   wire [7:0] rmux = isdat ? rxdat[pidx] : stat[pidx];
   wire tick = (tick_cnt_ff == 16'(TICK_DIV - 1));
   wire wait_done = bus.cpu_wait_ack | (wcnt_ff == 8'(WAIT_CYC));
   assign bus.din = din_ff;
   assign bus.din_oe_n = oe_n_ff;
   assign bus.cpu_ready_line = rdy_ff;
   // strobe edge history, read data drive (one cycle behind a selected strobe) and 16x divider
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_ff <= '0;
         wr_n_q_ff   <= 1'b1;
         bin_q_ff    <= 1'b0;
         rdsel_q_ff  <= 1'b0;
         din_ff      <= 8'h00;
         oe_n_ff     <= 1'b1;
      end else begin
         tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 16'h0001;
         wr_n_q_ff   <= bus.cpu_write_strobe_n;
         bin_q_ff    <= bus.cpu_bus_in_strobe;
         rdsel_q_ff  <= rd_sel;
         din_ff      <= rmux;
         oe_n_ff     <= ~(rd_sel & bus.cpu_bus_in_strobe);
      end
   end
   // wait state: ready drops at the start of every selected input cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdy_ff  <= 1'b1;
         wcnt_ff <= 8'h00;
      end else if (rd_sel & ~rdsel_q_ff) begin
         rdy_ff  <= 1'b0;
         wcnt_ff <= 8'h00;
      end else if (!rdy_ff) begin
         rdy_ff  <= wait_done;
         wcnt_ff <= wcnt_ff + 8'h01;
      end
   end
   // ---------------------------------------------------------------
   // per port logic
   // ---------------------------------------------------------------
   for (genvar p = 0; p < 2; p++) begin : g_port
      logic [7:0]  ctrl_ff, rdat_ff, fq_data;
      logic [11:0] txfr_ff;
      logic [8:0]  rsh_ff;
      logic [6:0]  txc_ff, rcnt_ff;
      logic [3:0]  txn_ff, rpos_ff;
      logic        txd_ff, rts_ff, irq_n_ff, fq_valid, fq_ready;
      logic        rx_holding_full_ff, fe_ff, pe_ff, ovrn_ff;
      wire [1:0] dv   = ctrl_ff[CR_DIV_HI:CR_DIV_LO];
      wire [2:0] fmt  = ctrl_ff[CR_FMT_HI:CR_FMT_LO];
      wire [1:0] txc  = ctrl_ff[CR_TXC_HI:CR_TXC_LO];
      wire mrst = (dv == DIV_MRST);
      // divide 64 on a 16x tick yields a quarter of the strapped rate
      wire [6:0] divn = (dv == DIV_64) ? DIVN_64 :
                        (dv == DIV_16) ? DIVN_16 : DIVN_1;
      wire nb8   = fmt[2];
      wire paren = ~fmt[2] | fmt[1];
      wire odd   = fmt[0];
      wire stop2 = fmt[2] ? (fmt[1:0] == 2'h0) : ~fmt[1];
      wire [3:0] flen = 4'h9 + {3'h0, nb8} + {3'h0, paren} + {3'h0, stop2};
      wire [7:0] dm  = nb8 ? fq_data : {1'b0, fq_data[6:0]};
      wire       tpar = (^dm) ^ odd;
      wire [11:0] frame = !nb8 ? {3'h7, tpar, fq_data[6:0], 1'b0} :
                          paren ? {2'h3, tpar, fq_data, 1'b0} : {3'h7, fq_data, 1'b0};
      wire tx_idle = (txn_ff == 4'h0);
      wire tbit = tick & (txc_ff == 7'h00);
      wire tx_pop = tx_idle & fq_valid & ~mrst;
      wire wr_ctl = wr_pulse & (pidx == 1'(p)) & ~isdat;
      wire wr_dat = wr_pulse & (pidx == 1'(p)) & isdat;
      wire rd_dat = rd_pulse & (pidx == 1'(p)) & isdat;
      wire rsamp = tick & (rpos_ff != 4'h0) & (rcnt_ff == 7'h00);
      wire rstart = tick & (rpos_ff == 4'h0) & ~rxd[p];
      wire [3:0] rlast = 4'h9 + {3'h0, nb8} + {3'h0, paren};          // first stop bit
      wire rdone = rsamp & (rpos_ff == rlast);
      wire [7:0] rdm = nb8 ? rsh_ff[7:0] : {1'b0, rsh_ff[6:0]};
      wire rpb = nb8 ? rsh_ff[8] : rsh_ff[7];
      wire txie = (txc == TXC_IE);
      wire irq = (ctrl_ff[CR_RXIE] & (rx_holding_full_ff | ovrn_ff)) | (txie & fq_ready);
      assign stat[p]  = {~irq_n_ff, pe_ff, ovrn_ff, fe_ff, 2'h0,
                         fq_ready, rx_holding_full_ff};
      assign rxdat[p] = rdat_ff;
      assign txd[p]   = txd_ff;
      assign rts_n[p] = rts_ff;
      assign irq_n[p] = irq_n_ff;
      sio_fifo #(.W(8), .D(FIFO_D)) u_txq (.mclk(mclk), .resetn(resetn), .clr(mrst),
         .in_valid(wr_dat & ~mrst), .in_ready(fq_ready), .in_data(bus.dout),
         .out_valid(fq_valid), .out_ready(tx_pop), .out_data(fq_data));
      // write-only control (starts in master reset) and transmitter, lsb first, one bit every divn ticks
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            ctrl_ff  <= CR_RESET;
            txfr_ff  <= 12'hFFF;
            txn_ff   <= 4'h0;
            txc_ff   <= 7'h00;
            txd_ff   <= 1'b1;
            rts_ff   <= 1'b0;
            irq_n_ff <= 1'b1;
         end else begin
            if (wr_ctl) begin
               ctrl_ff <= bus.dout;
            end
            rts_ff   <= txc[1];
            irq_n_ff <= ~(irq & ~mrst);
            txd_ff   <= (txc == TXC_BRK) ? 1'b0 : txfr_ff[0];
            if (mrst) begin
               txfr_ff <= 12'hFFF;
               txn_ff  <= 4'h0;
               txc_ff  <= 7'h00;
            end else if (tx_pop) begin
               txfr_ff <= frame;
               txn_ff  <= flen;
               txc_ff  <= divn - 7'h01;
            end else if (!tx_idle && tick) begin
               txc_ff <= (txc_ff == 7'h00) ? divn - 7'h01 : txc_ff - 7'h01;
               if (tbit) begin
                  txfr_ff <= {1'b1, txfr_ff[11:1]};
                  txn_ff  <= txn_ff - 4'h1;
               end
            end
         end
      end
      // receiver: mid-bit sampling, checks parity and first stop bit
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            rsh_ff  <= 9'h000;
            rpos_ff <= 4'h0;
            rcnt_ff <= 7'h00;
         end else if (mrst) begin
            rpos_ff <= 4'h0;
         end else if (rstart) begin
            rpos_ff <= 4'h1;
            rcnt_ff <= divn >> 1;
         end else if (tick && rpos_ff != 4'h0) begin
            rcnt_ff <= (rcnt_ff == 7'h00) ? divn - 7'h01 : rcnt_ff - 7'h01;
            if (rsamp) begin
               if ((rpos_ff == 4'h1 && rxd[p]) || rdone) begin
                  rpos_ff <= 4'h0;                                    // false start or done
               end else begin
                  rpos_ff <= rpos_ff + 4'h1;
                  if (rpos_ff != 4'h1) begin
                     rsh_ff[rpos_ff - 4'h2] <= rxd[p];
                  end
               end
            end
         end
      end
      // receive flags: a new character wins over a data read in the same cycle
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            rx_holding_full_ff <= 1'b0;
            fe_ff   <= 1'b0;
            pe_ff   <= 1'b0;
            ovrn_ff <= 1'b0;
            rdat_ff <= 8'h00;
         end else if (mrst) begin
            rx_holding_full_ff <= 1'b0;
            fe_ff   <= 1'b0;
            pe_ff   <= 1'b0;
            ovrn_ff <= 1'b0;
         end else if (rdone && rx_holding_full_ff && !rd_dat) begin
            ovrn_ff <= 1'b1;                                          // unread char kept
         end else if (rdone) begin
            rx_holding_full_ff <= 1'b1;
            rdat_ff <= rdm;
            fe_ff   <= ~rxd[p];
            pe_ff   <= paren & (((^rdm) ^ odd) != rpb);
            ovrn_ff <= 1'b0;
         end else if (rd_dat) begin
            rx_holding_full_ff <= 1'b0;
            ovrn_ff <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** rtl/sio_cpu.sv ***
// processor end: runs IN/OUT machine cycles on the i/o bus
`timescale 1ns/1ps
`default_nettype none
module sio_cpu
   import sio_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       resetn,
   cpu_io_if.cpu           bus,
   input  wire logic       req,
   input  wire logic [7:0] req_op,
   input  wire logic [7:0] req_addr,
   input  wire logic [7:0] req_wdata,
   input  wire logic       init_req,
   input  wire logic [7:0] init_addr,
   output logic            busy,
   output logic            done,
   output logic            err,
   output logic [7:0]      rdata
);
   typedef enum logic [7:0] {
      S_IDLE = 8'h01, S_M1 = 8'h02, S_M2 = 8'h04, S_T1 = 8'h08,
      S_T2 = 8'h10, S_WR = 8'h20, S_RD = 8'h40, S_FIN = 8'h80
   } cyc_e;
   cyc_e       st_ff;
   logic       isin_ff, init2_ff;
   logic [7:0] a_ff, d_ff, rd_ff;
   logic [3:0] cnt_ff;
   logic       done_ff, err_ff, rs_ff, ws_ff, bin_ff, wn_ff, ack_ff;
   // a request is refused unless it is IN or OUT and avoids the panel address
   wire op_ok  = (req_op == OP_IN) | (req_op == OP_OUT);
   wire adr_ok = (req_addr != ADDR_PANEL) & (init_addr != ADDR_PANEL | ~init_req);
   wire cnt_end = (cnt_ff >= 4'(STB_CYC - 1));
   assign bus.addr = {a_ff, a_ff};
   assign bus.dout = d_ff;
   assign bus.io_read_cycle_status  = rs_ff;
   assign bus.io_write_cycle_status = ws_ff;
   assign bus.cpu_bus_in_strobe  = bin_ff;
   assign bus.cpu_write_strobe_n = wn_ff;
   assign bus.cpu_wait_ack = ack_ff;
   assign busy  = (st_ff != S_IDLE);
   assign done  = done_ff;
   assign err   = err_ff;
   assign rdata = rd_ff;
   // machine cycle sequencer: fetch, fetch, then the i/o cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= S_IDLE;
         isin_ff <= 1'b0;
         init2_ff <= 1'b0;
         a_ff <= 8'h00;
         d_ff <= 8'h00;
         rd_ff <= 8'h00;
         cnt_ff <= 4'h0;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         rs_ff <= 1'b0;
         ws_ff <= 1'b0;
         bin_ff <= 1'b0;
         wn_ff <= 1'b1;
         ack_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         unique case (st_ff)
            S_IDLE: begin
               if (init_req && adr_ok) begin
                  isin_ff <= 1'b0;
                  a_ff <= init_addr;
                  d_ff <= INIT_RST;
                  init2_ff <= 1'b1;
                  st_ff <= S_M1;
               end else if (req && op_ok && adr_ok) begin
                  isin_ff <= (req_op == OP_IN);
                  a_ff <= req_addr;
                  d_ff <= req_wdata;
                  st_ff <= S_M1;
               end else if (req || init_req) begin
                  err_ff <= 1'b1;
               end
            end
            S_M1: st_ff <= S_M2;
            S_M2: st_ff <= S_T1;
            S_T1: begin
               rs_ff <= isin_ff;
               ws_ff <= ~isin_ff;
               st_ff <= S_T2;
            end
            S_T2: begin
               cnt_ff <= 4'h0;
               bin_ff <= isin_ff;
               wn_ff <= isin_ff;
               st_ff <= isin_ff ? S_RD : S_WR;
            end
            S_WR: begin
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_end) begin
                  wn_ff <= 1'b1;
                  st_ff <= S_FIN;
               end
            end
            S_RD: begin
               // hold the strobe while the board stretches the cycle
               ack_ff <= ~bus.cpu_ready_line;
               if (cnt_ff != 4'hF) begin
                  cnt_ff <= cnt_ff + 4'h1;
               end
               if (cnt_end && bus.cpu_ready_line && !ack_ff) begin
                  rd_ff <= bus.din;
                  bin_ff <= 1'b0;
                  st_ff <= S_FIN;
               end
            end
            S_FIN: begin
               rs_ff <= 1'b0;
               ws_ff <= 1'b0;
               if (init2_ff) begin
                  init2_ff <= 1'b0;
                  d_ff <= INIT_RUN;
                  st_ff <= S_M1;
               end else begin
                  done_ff <= 1'b1;
                  st_ff <= S_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** rtl/sio_pkg.sv ***
// shared constants for the dual serial port board and its processor end
package sio_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ   = 20_000_000;
   localparam int WAIT_NS  = 500;
   localparam int WAIT_CYC = (WAIT_NS * (CLK_HZ / 1_000_000)) / 1000; // longest, rounds down
   localparam int STB_CYC  = 3;           // processor strobe length in mclk cycles
   localparam int TICK_DEF = 130;         // mclk cycles per 16x bit clock tick
   localparam int FIFO_D   = 16;
   // ---------------------------------------------------------------
   // processor instruction and address
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_IN      = 8'hDB; // octal 333
   localparam logic [7:0] OP_OUT     = 8'hD3; // octal 323
   localparam logic [7:0] ADDR_PANEL = 8'hFF; // front panel switch location
   localparam logic [7:0] INIT_RST   = 8'h03; // octal 003
   localparam logic [7:0] INIT_RUN   = 8'hB1; // octal 261
   localparam int A_REG  = 0;
   localparam int A_PORT = 1;
   localparam int A_BLO  = 2;
   localparam int A_BHI  = 7;
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CR_DIV_LO = 0;
   localparam int CR_DIV_HI = 1;
   localparam int CR_FMT_LO = 2;
   localparam int CR_FMT_HI = 4;
   localparam int CR_TXC_LO = 5;
   localparam int CR_TXC_HI = 6;
   localparam int CR_RXIE   = 7;
   localparam logic [7:0] CR_RESET  = 8'h03;
   localparam logic [1:0] DIV_1     = 2'h0;
   localparam logic [1:0] DIV_16    = 2'h1;
   localparam logic [1:0] DIV_64    = 2'h2;
   localparam logic [1:0] DIV_MRST  = 2'h3;
   localparam logic [1:0] TXC_IE    = 2'h1;
   localparam logic [1:0] TXC_BRK   = 2'h3;
   localparam logic [6:0] DIVN_1    = 7'h01;
   localparam logic [6:0] DIVN_16   = 7'h10;
   localparam logic [6:0] DIVN_64   = 7'h40;
   // ---------------------------------------------------------------
   // status register fields
   // ---------------------------------------------------------------
   localparam int ST_RX_HOLDING_FULL = 0;
   localparam int ST_TX_HOLDING_EMPTY = 1;
   localparam int ST_FE   = 4;
   localparam int ST_OVRN = 5;
   localparam int ST_PE   = 6;
   localparam int ST_IRQ  = 7;
endpackage

// *** sim/dual_serial_port_bus_ctrl_test.sv ***
// testbench: processor end and board joined on the i/o bus, serial lines looped back
`timescale 1ns/1ps
`default_nettype none
module dual_serial_port_bus_ctrl_test
   import sio_pkg::*;
;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   logic       mclk, resetn, req, init_req, busy, done, err, er;
   logic [7:0] req_op, req_addr, req_wdata, rdata, rd;
   logic [1:0] txd, rts_n, irq_n;
   int         error_cnt, checks_done, n;
   cpu_io_if bus ();
   // txd feeds rxd so the receive path is exercised by our own frames
   sio_board #(.TICK_DIV(2)) i_sio_board (.mclk(mclk), .resetn(resetn), .bus(bus),
      .base_sel(6'h11), .rxd(txd), .txd(txd), .rts_n(rts_n), .irq_n(irq_n));
   sio_cpu i_sio_cpu (.mclk(mclk), .resetn(resetn), .bus(bus), .req(req), .req_op(req_op),
      .req_addr(req_addr), .req_wdata(req_wdata), .init_req(init_req), .init_addr(8'h44),
      .busy(busy), .done(done), .err(err), .rdata(rdata));
   sio_bus_assertions i_sio_bus_assertions (.mclk(mclk), .resetn(resetn), .addr(bus.addr),
      .base_sel(6'h11), .din_oe_n(bus.din_oe_n), .io_read_cycle_status(bus.io_read_cycle_status),
      .io_write_cycle_status(bus.io_write_cycle_status),
      .cpu_bus_in_strobe(bus.cpu_bus_in_strobe), .cpu_write_strobe_n(bus.cpu_write_strobe_n),
      .cpu_ready_line(bus.cpu_ready_line), .cpu_wait_ack(bus.cpu_wait_ack));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one IN or OUT instruction; bounded wait for done or err
   task automatic cpu_op(input logic [7:0] op, input logic [7:0] a, input logic [7:0] w);
      @(negedge mclk);
      req_op = op;
      req_addr = a;
      req_wdata = w;
      req = 1'b1;
      @(negedge mclk);
      req = 1'b0;
      for (n = 0; n < 60 && !(done === 1'b1 || err === 1'b1); n++) @(negedge mclk);
      rd = rdata;
      er = (err === 1'b1);
      if (n == 60) error_cnt++;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // clock, watchdog, tests
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // the whole run needs a few thousand cycles; this is far beyond it
   initial begin
      #(50 * 20000);
      error_cnt++;
      wrap_up();
   end
   initial begin
      {resetn, req, init_req, req_op, req_addr, req_wdata} = '0;
      error_cnt = 0;
      checks_done = 0;
      repeat (10) @(negedge mclk);
      resetn = 1'b1;
      @(negedge mclk);
      init_req = 1'b1;
      @(negedge mclk);
      init_req = 1'b0;
      for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge mclk);
      if (n == 100) error_cnt++;
      cpu_op(OP_IN, 8'h44, 8'h00);
      check(rd, 8'h82);
      check({6'h00, irq_n}, 8'h02);
      $display("test init done");
      cpu_op(OP_OUT, 8'h45, 8'h5A);
      for (int k = 0; k < 40; k++) begin
         cpu_op(OP_IN, 8'h44, 8'h00);
         if (rd[0] === 1'b1) break;
         repeat (20) @(negedge mclk);
      end
      check(rd, 8'h83);
      cpu_op(OP_IN, 8'h45, 8'h00);
      check(rd, 8'h5A);
      cpu_op(OP_IN, 8'h44, 8'h00);
      check(rd, 8'h82);
      $display("test loopback done");
      cpu_op(OP_OUT, 8'h46, 8'h40);
      check({6'h00, rts_n}, 8'h02);
      cpu_op(OP_OUT, 8'h46, 8'h60);
      repeat (4) @(negedge mclk);
      check({6'h00, txd}, 8'h01);
      cpu_op(OP_OUT, 8'h46, CR_RESET);
      repeat (4) @(negedge mclk);
      check({4'h0, rts_n, txd}, 8'h03);
      $display("test port control done");
      cpu_op(OP_OUT, 8'h40, CR_RESET);
      cpu_op(OP_IN, 8'h48, 8'h00);
      cpu_op(OP_IN, 8'h44, 8'h00);
      check(rd, 8'h82);
      cpu_op(OP_IN, ADDR_PANEL, 8'h00);
      check({7'h00, er}, 8'h01);
      $display("test decode done");
      // seven bits, odd parity, divide 64: a character needs about 1220 cycles here
      cpu_op(OP_OUT, 8'h44, CR_RESET);
      cpu_op(OP_OUT, 8'h44, 8'h0E);
      cpu_op(OP_OUT, 8'h45, 8'hC5);
      repeat (1100) @(negedge mclk);
      cpu_op(OP_IN, 8'h44, 8'h00);
      check(rd, 8'h02);
      repeat (200) @(negedge mclk);
      cpu_op(OP_IN, 8'h44, 8'h00);
      check(rd, 8'h03);
      cpu_op(OP_IN, 8'h45, 8'h00);
      check(rd, 8'h45);
      $display("test divide 64 done");
      wrap_up();
   end
endmodule
`default_nettype wire

// *** sim/sio_bus_assertions.sv ***
// protocol checks on the processor i/o bus between board and processor end
`timescale 1ns/1ps
`default_nettype none
module sio_bus_assertions (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic [15:0] addr,
   input wire logic [5:0]  base_sel,
   input wire logic        din_oe_n,
   input wire logic        io_read_cycle_status,
   input wire logic        io_write_cycle_status,
   input wire logic        cpu_bus_in_strobe,
   input wire logic        cpu_write_strobe_n,
   input wire logic        cpu_ready_line,
   input wire logic        cpu_wait_ack
);
   // ---------------------------------------------------------------
   // decode and clocking
   // ---------------------------------------------------------------
   // jumper match, the only thing that may make the board answer
   wire logic hit = addr[7:2] == base_sel;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_addr_mirror: assert property ((io_read_cycle_status || io_write_cycle_status)
      |-> addr[15:8] == addr[7:0]) else $error("address halves differ");
   a_one_status: assert property (!(io_read_cycle_status && io_write_cycle_status))
      else $error("both cycle status lines high");
   a_strobe_status: assert property (cpu_bus_in_strobe |-> io_read_cycle_status)
      else $error("bus-in strobe outside read cycle");
   a_write_status: assert property (!cpu_write_strobe_n |-> io_write_cycle_status)
      else $error("write strobe outside write cycle");
   a_drive_follows: assert property ($rose(cpu_bus_in_strobe) && io_read_cycle_status && hit
      |=> !din_oe_n) else $error("board not driving after strobe");
   // past values, because the drive outlives the strobe by one cycle
   a_foreign_quiet: assert property (!din_oe_n |-> $past(io_read_cycle_status)
      && $past(addr[7:2]) == base_sel) else $error("data bus driven without match");
   a_ready_drops: assert property ($rose(io_read_cycle_status) && hit
      |=> !cpu_ready_line) else $error("no wait state on read");
   a_ready_bounded: assert property ($fell(cpu_ready_line) |-> ##[1:11] cpu_ready_line)
      else $error("wait state too long");
   a_ack_release: assert property (cpu_wait_ack && !cpu_ready_line |=> cpu_ready_line)
      else $error("ready not released by wait ack");
   a_write_nowait: assert property (io_write_cycle_status |-> cpu_ready_line)
      else $error("wait state on write");
   c_read: cover property (!din_oe_n);
   c_write: cover property (!cpu_write_strobe_n && hit);
   c_ack: cover property (cpu_wait_ack && !cpu_ready_line);
endmodule
`default_nettype wire
